// [src/tma_target_memory_app.sv]
// Target memory application: four 2 KB regions behind the endpoint core's
// completer request stream, answering on the completer completion stream.
// Assumes the core has already matched every request against a BAR.
// Function
// - Four 2 KB regions, 8192 bytes total
// - One dual-port 8 KB memory, a 2 KB slice per region
// - Region chosen from descriptor bits 114:112
// - 000 low, 001 high, 110 ROM; I/O off
// - Single-dword I/O and memory requests served
// - Reads return completion with one dword
// - I/O writes get successful dataless completion
// - One-dword writes store payload at address
// - Write extracts address, data, enables region
// - Ready held low during memory write
// - BAR0 EEC CCCCDDDD raises legacy interrupt
// - BAR0 EEC EEEEFFFF raises MSI
// - BAR0 EEC DEADBEEF raises MSI-X
// - Longer requests accepted fully, then dropped
// - Unsupported extra BAR hits get no completion
// - Addresses beyond 2 KB wrap onto region
// - One I/O BAR, disabled unless configured
// - Works on 64, 128, 256-bit paths
// - No new read until completion sent
// - No new write until write stored
`timescale 1ns/1ps

module tma_target_memory_app #(
    parameter int         DATA_W    = 64,
    parameter bit         IO_ENABLE = 1'b0,
    parameter logic [2:0] IO_BAR_ID = 3'h2
) (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic [DATA_W-1:0]   cq_tdata_in,
    input  wire logic                cq_tvalid_in,
    input  wire logic                cq_tlast_in,
    input  wire logic [3:0]          cq_first_be_in,
    output logic                     completer_request_ready_out,
    output logic [DATA_W-1:0]        cc_tdata_out,
    output logic [DATA_W/32-1:0]     cc_tkeep_out,
    output logic                     cc_tvalid_out,
    output logic                     cc_tlast_out,
    input  wire logic                cc_tready_in,
    output logic                     legacy_intr_out,
    output logic                     msi_intr_out,
    output logic                     msix_intr_out
);

    // ************************************************************
    // Sizes derived from the datapath width
    // ************************************************************
    localparam int KW     = DATA_W / 32;
    localparam int NB_RX  = (tma_pkg::RQ_CAP_BITS + DATA_W - 1) / DATA_W;
    localparam int NB_CC  = (tma_pkg::CC_BITS + DATA_W - 1) / DATA_W;
    localparam int BW     = $clog2(NB_RX + 1);
    localparam int TW     = (NB_CC > 1) ? $clog2(NB_CC) : 1;

    // ************************************************************
    // Storage and state
    // ************************************************************
    tma_pkg::tma_state_e         state;
    tma_pkg::tma_state_e         next_state;
    logic [NB_RX*DATA_W-1:0]     cap;
    logic [BW-1:0]               rx_beat;
    logic [3:0]                  first_be;
    logic [31:0]                 rd_data;
    logic [TW-1:0]               tx_beat;
    logic [31:0]                 mem [0:(tma_pkg::TOTAL_BYTES/4)-1];

    // ************************************************************
    // Request decode
    // ************************************************************
    wire logic [3:0]  req_type   = cap[tma_pkg::RQ_TYPE_HI:tma_pkg::RQ_TYPE_LO];
    wire logic [10:0] dw_count   = cap[tma_pkg::RQ_DWCNT_HI:tma_pkg::RQ_DWCNT_LO];
    wire logic [2:0]  bar_hit_select = cap[tma_pkg::RQ_BAR_HI:tma_pkg::RQ_BAR_LO];
    wire logic [15:0] req_id     = cap[tma_pkg::RQ_REQID_LO +: 16];
    wire logic [7:0]  req_tag    = cap[tma_pkg::RQ_TAG_LO +: 8];
    wire logic [7:0]  req_func   = cap[tma_pkg::RQ_FUNC_LO +: 8];
    wire logic [2:0]  req_tc     = cap[tma_pkg::RQ_TC_LO +: 3];
    wire logic [2:0]  req_attr   = cap[tma_pkg::RQ_ATTR_LO +: 3];
    wire logic [31:0] wr_dword   = cap[tma_pkg::RQ_DATA_LO +: 32];
    wire logic [11:0] byte_addr  = {cap[11:tma_pkg::RQ_ADDR_LO], 2'b00};

    // Only the low word bits are kept, so wide apertures alias onto 2 KB
    wire logic [tma_pkg::WORD_AW-1:0] word_idx =
        cap[tma_pkg::RQ_ADDR_LO +: tma_pkg::WORD_AW];

    // One identifier per type; further BARs of a type fall through unmatched
    wire logic region_mem_lo_addr   = (bar_hit_select == tma_pkg::BAR_MEM_LO);
    wire logic region_mem_hi_addr   = (bar_hit_select == tma_pkg::BAR_MEM_HI);
    wire logic region_expansion_rom = (bar_hit_select == tma_pkg::BAR_EROM);
    wire logic region_io_space      = IO_ENABLE && (bar_hit_select == IO_BAR_ID);
    wire logic region_hit = region_mem_lo_addr | region_mem_hi_addr |
                            region_expansion_rom | region_io_space;

    // Region number selects one of four 2 KB slices of the array
    wire logic [1:0] region_sel = region_mem_lo_addr   ? 2'h0 :
                                  region_mem_hi_addr   ? 2'h1 :
                                  region_expansion_rom ? 2'h2 : 2'h3;
    wire logic [tma_pkg::MEM_AW-1:0] mem_idx = {region_sel, word_idx};

    wire logic is_rd = (req_type == tma_pkg::TYPE_MEM_RD) ||
                       (req_type == tma_pkg::TYPE_IO_RD);
    wire logic is_wr = (req_type == tma_pkg::TYPE_MEM_WR) ||
                       (req_type == tma_pkg::TYPE_IO_WR);
    wire logic is_io_wr = (req_type == tma_pkg::TYPE_IO_WR);

    // Anything but a single dword is swallowed without an answer
    wire logic req_ok   = region_hit && (dw_count == 11'h001) && (is_rd || is_wr);
    wire logic do_write = (state == tma_pkg::TMA_EXEC) && req_ok && is_wr;
    wire logic do_read  = (state == tma_pkg::TMA_EXEC) && req_ok && is_rd;
    wire logic need_cpl = is_rd || is_io_wr;

    // Special writes to BAR0
    wire logic intr_hit = do_write && (bar_hit_select == tma_pkg::BAR_ZERO) &&
                          (byte_addr == tma_pkg::INTR_ADDR);

    // ************************************************************
    // Receive side handshake
    // ************************************************************
    // Ready only while collecting; every other state stalls the core, which
    // keeps the control simple at the cost of stream throughput.
    assign completer_request_ready_out = (state == tma_pkg::TMA_RECV);
    wire logic rx_take = completer_request_ready_out && cq_tvalid_in;

    // ************************************************************
    // Completion assembly
    // ************************************************************
    wire logic [1:0] be_lo = first_be[0] ? 2'h0 : first_be[1] ? 2'h1 :
                             first_be[2] ? 2'h2 : first_be[3] ? 2'h3 : 2'h0;
    wire logic [1:0] be_hi = first_be[3] ? 2'h3 : first_be[2] ? 2'h2 :
                             first_be[1] ? 2'h1 : 2'h0;
    wire logic [12:0] rd_bytes = (first_be == 4'h0) ? 13'h0001 :
                                 13'({11'h000, be_hi} - {11'h000, be_lo} + 13'h0001);
    wire logic [12:0] cpl_bytes = is_rd ? rd_bytes : 13'h0004;
    wire logic [6:0]  cpl_lower = is_rd ? {cap[6:2], be_lo} : 7'h00;
    wire logic [10:0] cpl_dws   = is_rd ? 11'h001 : 11'h000;

    // Identity fields come straight from the stored request
    wire logic [tma_pkg::CC_BITS-1:0] cc_pkt = {
        rd_data,
        1'b0, req_attr, req_tc, 1'b0, 8'h00, req_func,
        req_tag, req_id,
        1'b0, 1'b0, tma_pkg::CPL_SUCCESS, cpl_dws,
        3'h0, cpl_bytes, 6'h00, 2'b00, 1'b0, cpl_lower
    };
    wire logic [NB_CC*DATA_W-1:0] cc_buf = (NB_CC*DATA_W)'(cc_pkt);

    localparam int CCB = $clog2(tma_pkg::CC_DW_RD + 1);
    wire logic [CCB-1:0] cc_dws = is_rd ? CCB'(tma_pkg::CC_DW_RD) :
                                          CCB'(tma_pkg::CC_DW_NODAT);
    wire logic [TW-1:0] cc_beats_m1 = TW'((32'(cc_dws) + KW - 1) / KW - 1);

    function automatic logic [KW-1:0] keep_of(input logic [TW-1:0]  beat,
                                              input logic [CCB-1:0] dws);
        logic [KW-1:0] k;
        k = '0;
        for (int j = 0; j < KW; j++) begin
            k[j] = ((32'(beat) * KW + j) < 32'(dws));
        end
        return k;
    endfunction

    wire logic [TW-1:0] tx_next  = (state == tma_pkg::TMA_LOAD) ? '0 : TW'(tx_beat + 1'b1);
    wire logic          tx_step  = cc_tvalid_out && cc_tready_in;
    wire logic          tx_done  = tx_step && cc_tlast_out;

    // ************************************************************
    // State sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            tma_pkg::TMA_RECV: begin
                if (rx_take && cq_tlast_in) begin
                    next_state = tma_pkg::TMA_EXEC;
                end
            end
            tma_pkg::TMA_EXEC: begin
                if (req_ok && need_cpl) begin
                    next_state = tma_pkg::TMA_LOAD;
                end else begin
                    next_state = tma_pkg::TMA_RECV;
                end
            end
            tma_pkg::TMA_LOAD: begin
                next_state = tma_pkg::TMA_CPL;
            end
            tma_pkg::TMA_CPL: begin
                if (tx_done) begin
                    next_state = tma_pkg::TMA_RECV;
                end
            end
            default: begin
                next_state = tma_pkg::TMA_RECV;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= tma_pkg::TMA_RECV;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Request capture
    // ************************************************************
    // Beats past the descriptor and first dword are taken but not kept
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_beat  <= '0;
            cap      <= '0;
            first_be <= 4'h0;
        end else if (rx_take) begin
            for (int i = 0; i < NB_RX; i++) begin
                if (32'(rx_beat) == i) begin
                    cap[i*DATA_W +: DATA_W] <= cq_tdata_in;
                end
            end
            if (rx_beat == '0) begin
                first_be <= cq_first_be_in;
            end
            if (cq_tlast_in) begin
                rx_beat <= '0;
            end else if (32'(rx_beat) < NB_RX) begin
                rx_beat <= BW'(rx_beat + 1'b1);
            end
        end
    end

    // ************************************************************
    // Region memory
    // ************************************************************
    // Write port and read port are separate, as in a dual-port RAM
    always_ff @(posedge clk_in) begin
        if (do_write) begin
            for (int b = 0; b < 4; b++) begin
                if (first_be[b]) begin
                    mem[mem_idx][b*8 +: 8] <= wr_dword[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data <= 32'h00000000;
        end else if (do_read) begin
            rd_data <= mem[mem_idx];
        end
    end

    // ************************************************************
    // Completion output
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cc_tdata_out  <= '0;
            cc_tkeep_out  <= '0;
            cc_tvalid_out <= 1'b0;
            cc_tlast_out  <= 1'b0;
            tx_beat       <= '0;
        end else if ((state == tma_pkg::TMA_LOAD) || (tx_step && !cc_tlast_out)) begin
            cc_tdata_out  <= cc_buf[32'(tx_next)*DATA_W +: DATA_W];
            cc_tkeep_out  <= keep_of(tx_next, cc_dws);
            cc_tvalid_out <= 1'b1;
            cc_tlast_out  <= (tx_next == cc_beats_m1);
            tx_beat       <= tx_next;
        end else if (tx_done) begin
            cc_tvalid_out <= 1'b0;
            cc_tlast_out  <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupt triggers
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            legacy_intr_out <= 1'b0;
            msi_intr_out    <= 1'b0;
            msix_intr_out   <= 1'b0;
        end else begin
            legacy_intr_out <= intr_hit && (wr_dword == tma_pkg::INTR_LEGACY_DW);
            msi_intr_out    <= intr_hit && (wr_dword == tma_pkg::INTR_MSI_DW);
            msix_intr_out   <= intr_hit && (wr_dword == tma_pkg::INTR_MSIX_DW);
        end
    end

endmodule

// [src/tma_pkg.sv]
// Constants shared by the target memory application.
// Assumes the completer request and completion descriptor layouts of the endpoint core.
package tma_pkg;

    // ************************************************************
    // Region memory geometry
    // ************************************************************
    localparam int REGION_BYTES = 2048;
    localparam int REGION_COUNT = 4;
    localparam int TOTAL_BYTES  = 8192;
    localparam int REGION_WORDS = REGION_BYTES / 4;
    localparam int WORD_AW      = $clog2(REGION_WORDS);
    localparam int MEM_AW       = $clog2(TOTAL_BYTES / 4);

    // ************************************************************
    // Completer request descriptor fields
    // ************************************************************
    localparam int RQ_ADDR_LO   = 2;
    localparam int RQ_DWCNT_LO  = 64;
    localparam int RQ_DWCNT_HI  = 74;
    localparam int RQ_TYPE_LO   = 75;
    localparam int RQ_TYPE_HI   = 78;
    localparam int RQ_REQID_LO  = 80;
    localparam int RQ_TAG_LO    = 96;
    localparam int RQ_FUNC_LO   = 104;
    localparam int RQ_BAR_LO    = 112;
    localparam int RQ_BAR_HI    = 114;
    localparam int RQ_TC_LO     = 121;
    localparam int RQ_ATTR_LO   = 124;
    localparam int RQ_DATA_LO   = 128;
    localparam int RQ_CAP_BITS  = 160;

    // Request type encodings
    localparam logic [3:0] TYPE_MEM_RD = 4'h0;
    localparam logic [3:0] TYPE_MEM_WR = 4'h1;
    localparam logic [3:0] TYPE_IO_RD  = 4'h2;
    localparam logic [3:0] TYPE_IO_WR  = 4'h3;

    // BAR hit identifiers
    localparam logic [2:0] BAR_MEM_LO  = 3'h0;
    localparam logic [2:0] BAR_MEM_HI  = 3'h1;
    localparam logic [2:0] BAR_EROM    = 3'h6;
    localparam logic [2:0] BAR_ZERO    = 3'h0;

    // Special writes that raise interrupts
    localparam logic [11:0] INTR_ADDR      = 12'hEEC;
    localparam logic [31:0] INTR_LEGACY_DW = 32'hCCCCDDDD;
    localparam logic [31:0] INTR_MSI_DW    = 32'hEEEEFFFF;
    localparam logic [31:0] INTR_MSIX_DW   = 32'hDEADBEEF;

    // Completion descriptor
    localparam int         CC_BITS     = 128;
    localparam int         CC_DW_RD    = 4;
    localparam int         CC_DW_NODAT = 3;
    localparam logic [2:0] CPL_SUCCESS = 3'h0;

    typedef enum logic [1:0] {
        TMA_RECV = 2'b00,
        TMA_EXEC = 2'b01,
        TMA_LOAD = 2'b11,
        TMA_CPL  = 2'b10
    } tma_state_e;

endpackage

// [bench/tma_monitor.sv]
// Concurrent checks on the target memory application ports.
// Assumes the 128-bit request path, one descriptor beat then one payload beat.
`timescale 1ns/1ps
module tma_checker #(
    parameter int DATA_W = 128
) (
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic [DATA_W-1:0]     cq_tdata_in,
    input wire logic                  cq_tvalid_in,
    input wire logic                  cq_tlast_in,
    input wire logic                  completer_request_ready_out,
    input wire logic [DATA_W-1:0]     cc_tdata_out,
    input wire logic [DATA_W/32-1:0]  cc_tkeep_out,
    input wire logic                  cc_tvalid_out,
    input wire logic                  cc_tlast_out,
    input wire logic                  cc_tready_in,
    input wire logic                  legacy_intr_out,
    input wire logic                  msi_intr_out,
    input wire logic                  msix_intr_out
);
    // ****************************************
    // Request tracking
    // ****************************************
    logic         in_pkt;
    logic [127:0] desc_q;
    wire          rdy   = completer_request_ready_out;
    wire          take  = cq_tvalid_in && rdy;
    wire          done  = take && cq_tlast_in;
    wire [127:0]  desc  = in_pkt ? desc_q : cq_tdata_in[127:0];
    wire [3:0]    kind  = desc[78:75];
    wire [2:0]    bar   = desc[114:112];
    wire          legal = desc[74:64] == 11'h1 && (bar == 3'h0 || bar == 3'h1 || bar == 3'h6);
    wire          rd    = done && legal && (kind == 4'h0 || kind == 4'h2);
    wire          iowr  = done && legal && kind == 4'h3;
    wire          memwr = done && legal && kind == 4'h1;
    wire          spec  = memwr && bar == 3'h0 && desc[11:2] == tma_pkg::INTR_ADDR[11:2];
    wire [31:0]   pl    = cq_tdata_in[31:0];

    always_ff @(posedge clk_in) begin
        if (rst_in) in_pkt <= 1'b0;
        else if (take) in_pkt <= !cq_tlast_in;
    end
    always_ff @(posedge clk_in) begin
        if (take && !in_pkt) desc_q <= cq_tdata_in[127:0];
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Memory write: one stalled cycle, then free again
    sequence stall_then_free;
        !rdy ##1 rdy;
    endsequence

    ready_drop_a: assert property (done |=> !rdy)
        else $error("ready stayed high after a request");
    read_cpl_a: assert property (rd |-> ##3 (cc_tvalid_out && cc_tkeep_out == 4'hF))
        else $error("read completion missing or wrong keep");
    iowr_cpl_a: assert property (iowr |-> ##3 (cc_tvalid_out && cc_tkeep_out == 4'h7))
        else $error("io write completion missing or wrong keep");
    memwr_free_a: assert property (memwr |=> stall_then_free)
        else $error("write stall length wrong");
    drop_quiet_a: assert property (done && !legal |=> (!cc_tvalid_out)[*4] and ##1 rdy)
        else $error("refused request produced output");
    cpl_hold_a: assert property (cc_tvalid_out && !cc_tready_in |=>
        cc_tvalid_out && $stable(cc_tdata_out))
        else $error("completion changed while stalled");
    // One descriptor plus one dword fits a single 128-bit beat
    cpl_last_a: assert property (cc_tvalid_out |-> cc_tlast_out)
        else $error("completion not marked as last beat");
    cpl_blocks_a: assert property (cc_tvalid_out |-> !rdy)
        else $error("request accepted during completion");
    legacy_intr_a: assert property (spec && pl == tma_pkg::INTR_LEGACY_DW |->
        ##2 legacy_intr_out)
        else $error("legacy interrupt missing");
    msi_intr_a: assert property (spec && pl == tma_pkg::INTR_MSI_DW |->
        ##2 msi_intr_out)
        else $error("msi interrupt missing");
    msix_intr_a: assert property (spec && pl == tma_pkg::INTR_MSIX_DW |->
        ##2 msix_intr_out)
        else $error("msix interrupt missing");
endmodule

bind tma_target_memory_app tma_checker #(.DATA_W(DATA_W)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .cq_tdata_in(cq_tdata_in),
    .cq_tvalid_in(cq_tvalid_in), .cq_tlast_in(cq_tlast_in),
    .completer_request_ready_out(completer_request_ready_out),
    .cc_tdata_out(cc_tdata_out), .cc_tkeep_out(cc_tkeep_out),
    .cc_tvalid_out(cc_tvalid_out), .cc_tlast_out(cc_tlast_out), .cc_tready_in(cc_tready_in),
    .legacy_intr_out(legacy_intr_out), .msi_intr_out(msi_intr_out),
    .msix_intr_out(msix_intr_out));

// [bench/tma_core_model.sv]
// Behavioural endpoint core: forwards requests, takes completions with stalls.
// Assumes the 128-bit stream path; requests are issued through the send task.
`timescale 1ns/1ps
module tma_core_model (
    input  wire logic         clk_in,
    input  wire logic         ready_in,
    input  wire logic         cc_tvalid_in,
    input  wire logic [127:0] cc_tdata_in,
    input  wire logic         stall_in,
    output logic [127:0]      tdata_out,
    output logic              tvalid_out,
    output logic              tlast_out,
    output logic [3:0]        first_be_out,
    output logic              cc_tready_out,
    output logic [127:0]      cpl_data_out,
    output int                cpl_cnt_out
);
    logic [15:0] lfsr = 16'hACE1;
    initial begin
        tdata_out     = '0;
        tvalid_out    = 1'b0;
        tlast_out     = 1'b0;
        first_be_out  = 4'hF;
        cc_tready_out = 1'b1;
        cpl_cnt_out   = 0;
    end
    always @(posedge clk_in) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        cc_tready_out <= !stall_in || lfsr[0];
        if (cc_tvalid_in && cc_tready_out) begin
            cpl_cnt_out  <= cpl_cnt_out + 1;
            cpl_data_out <= cc_tdata_in;
        end
    end
    task automatic beat(input logic [127:0] d, input logic last);
        tvalid_out <= 1'b1;
        tdata_out  <= d;
        tlast_out  <= last;
        do @(negedge clk_in); while (!ready_in);
        @(posedge clk_in);
    endtask
    // Caller hands only BAR-matched requests, hit id already in the descriptor
    task automatic send(input logic [127:0] desc, input logic [31:0] pl, input logic has_pl);
        @(posedge clk_in);
        beat(desc, !has_pl);
        if (has_pl) beat({{3{~pl}}, pl}, 1'b1);
        tvalid_out <= 1'b0;
        tlast_out  <= 1'b0;
        tdata_out  <= ~tdata_out;
    endtask
endmodule

// [bench/tma_target_memory_app_tb.sv]
// Self-checking bench for the target memory application, 128-bit path.
// Assumes the core model drives requests and accepts completions.
`timescale 1ns/1ps
module tma_target_memory_app_tb;
    logic         clk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic         stall  = 1'b0;
    logic [127:0] tdata, cc_tdata, cpl_data;
    logic [3:0]   be, cc_tkeep;
    logic         tvalid, tlast, ready, cc_tvalid, cc_tlast, cc_tready, leg, msi, msix;
    int           cpl_cnt, n_fail, total_checks, cycles, n_leg, n_msi, n_msix;
    logic [31:0]  seed = 32'hA9044B28;
    logic [31:0]  mem [1536];
    logic [31:0]  addrs [48];

    always #2 clk_in = ~clk_in;

    tma_target_memory_app #(.DATA_W(128)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .cq_tdata_in(tdata), .cq_tvalid_in(tvalid),
        .cq_tlast_in(tlast), .cq_first_be_in(be), .completer_request_ready_out(ready),
        .cc_tdata_out(cc_tdata), .cc_tkeep_out(cc_tkeep), .cc_tvalid_out(cc_tvalid),
        .cc_tlast_out(cc_tlast), .cc_tready_in(cc_tready), .legacy_intr_out(leg),
        .msi_intr_out(msi), .msix_intr_out(msix));
    tma_core_model core_u (
        .clk_in(clk_in), .ready_in(ready), .cc_tvalid_in(cc_tvalid), .cc_tdata_in(cc_tdata),
        .stall_in(stall), .tdata_out(tdata), .tvalid_out(tvalid), .tlast_out(tlast),
        .first_be_out(be), .cc_tready_out(cc_tready), .cpl_data_out(cpl_data),
        .cpl_cnt_out(cpl_cnt));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [127:0] mk_desc(input logic [3:0] k, input logic [2:0] b,
                                             input logic [31:0] a, input logic [10:0] n);
        logic [127:0] d;
        d = {rnd(), rnd(), rnd(), rnd()};
        d[1:0] = 2'h0;
        d[63:32] = 32'h0;
        d[74:64] = n;
        d[78:75] = k;
        d[79] = 1'b0;
        d[111:104] = 8'h0;
        d[114:112] = b;
        d[127] = 1'b0;
        d[120:115] = 6'h0;
        d[31:2] = a[31:2];
        return d;
    endfunction
    function automatic logic [127:0] exp_cpl(input logic [127:0] d, input logic [31:0] v,
                                             input logic r);
        logic [127:0] e;
        e = '0;
        // Completions without data carry no lower address
        e[6:2] = r ? d[6:2] : 5'h00;
        e[28:16] = 13'h4;
        e[42:32] = {10'h0, r};
        e[63:48] = d[95:80];
        e[71:64] = d[103:96];
        e[91:89] = d[123:121];
        e[94:92] = d[126:124];
        e[127:96] = v;
        return e;
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [3:0] k, input logic [2:0] b, input logic [31:0] a,
                        input logic [10:0] n, input logic [31:0] pl);
        logic [127:0] d;
        logic [127:0] m;
        int           c0;
        int           ri;
        bit           ok;
        bit           r;
        d  = mk_desc(k, b, a, n);
        ok = n == 11'h1 && (b == 3'h0 || b == 3'h1 || b == 3'h6);
        r  = k == tma_pkg::TYPE_MEM_RD || k == tma_pkg::TYPE_IO_RD;
        ri = (b == 3'h6) ? 1024 + 32'(a[10:2]) : 512 * b + 32'(a[10:2]);
        c0 = cpl_cnt;
        stall <= rnd() > 32'h9FFFFFFF;
        core_u.send(d, pl, !r);
        if (ok && !r) mem[ri] = pl;
        @(negedge clk_in);
        for (int i = 0; i < 60 && !ready; i++) @(negedge clk_in);
        check(128'(cpl_cnt - c0), 128'(ok && k != tma_pkg::TYPE_MEM_WR));
        m = r ? '1 : {32'h0, {96{1'b1}}};
        if (ok && k != tma_pkg::TYPE_MEM_WR) begin
            check(cpl_data & m, exp_cpl(d, r ? mem[ri] : 0, r));
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        n_leg  <= n_leg + (leg === 1'b1);
        n_msi  <= n_msi + (msi === 1'b1);
        n_msix <= n_msix + (msix === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    logic [2:0]  bars [3] = '{3'h0, 3'h1, 3'h6};
    logic [31:0] codes [4] = '{tma_pkg::INTR_LEGACY_DW, tma_pkg::INTR_MSI_DW,
                               tma_pkg::INTR_MSIX_DW, tma_pkg::INTR_LEGACY_DW};
    logic [31:0] ra;
    logic [31:0] rb;

    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 48; i++) begin
            ra = rnd();
            rb = rnd();
            addrs[i] = {ra[31:13], 2'(i % 3), rb[10:2], 2'h0};
            xfer(ra[0] ? tma_pkg::TYPE_IO_WR : tma_pkg::TYPE_MEM_WR,
                 bars[i % 3], addrs[i], 11'h1, rnd());
        end
        // Reads use another alias of the same word to exercise the 2 KB wrap
        for (int i = 47; i >= 0; i--) begin
            ra = rnd();
            xfer(ra[0] ? tma_pkg::TYPE_IO_RD : tma_pkg::TYPE_MEM_RD, bars[i % 3],
                 addrs[i] ^ {ra[31:11], 11'h0}, 11'h1, 32'h0);
        end
        xfer(tma_pkg::TYPE_MEM_WR, 3'h0, addrs[0], 11'h2, 32'h5A5A5A5A);
        xfer(tma_pkg::TYPE_MEM_RD, 3'h1, addrs[1], 11'h2, 32'h0);
        xfer(tma_pkg::TYPE_MEM_RD, 3'h0, addrs[0], 11'h1, 32'h0);
        xfer(tma_pkg::TYPE_MEM_RD, 3'h2, addrs[1], 11'h1, 32'h0);
        xfer(tma_pkg::TYPE_IO_WR, 3'h7, addrs[2], 11'h1, 32'h1);
        for (int i = 0; i < 4; i++) begin
            xfer(tma_pkg::TYPE_MEM_WR, (i == 3) ? 3'h1 : 3'h0, 32'h00000EEC, 11'h1, codes[i]);
        end
        check(128'({n_leg[7:0], n_msi[7:0], n_msix[7:0]}), 128'h010101);
        complete_run();
    end
endmodule
